/* design/qlm_line_ctrl.sv */
/*
 * Line mode, termination, slew and RS485 direction/echo control for
 * channels three and four, plus interrupt forwarding for all channels.
 * Assumes UART pins and line receivers are asynchronous to sys_clk.
 */
`timescale 1ns/100ps
module qlm_line_ctrl
    import qlm_pkg::*;
#(
    parameter int N_UART = NUM_UART
)
(
    input  wire logic                sys_clk,
    input  wire logic                nrst,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [1:0]          uart_rts_n,
    input  wire logic [1:0]          uart_txd,
    input  wire logic [1:0]          line_rxd,
    input  wire logic [N_UART-1:0]   uart_irq_in,
    output logic [1:0]               uart_rxd,
    output logic [1:0]               line_drv_en,
    output logic [N_UART-1:0]        uart_irq_out,
    output logic                     ch3_rs232_enable,
    output logic                     ch3_rs422_enable,
    output logic                     ch3_termination_n,
    output logic                     ch4_termination_n,
    output logic                     ch3_slow_slew_n,
    output logic                     ch4_slow_slew_n,
    output logic                     ch4_rs485_enable,
    output logic                     irq
);
    if (N_UART != NUM_UART)
    begin : g_chk
        $error("qlm_line_ctrl serves exactly four channels");
    end

    function automatic qlm_mode_t ch3_mode(input logic en232,
                                           input logic en422);
        if (en232)
            return QLM_M232;
        else if (en422)
            return QLM_M422;
        else
            return QLM_M485;
    endfunction

    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        return {a == IRQ_MASK_OFF, a == IRQ_STAT_OFF,
                a == STAT_OFF, a == CTRL_OFF};
    endfunction

    logic [9:0]         sync1_r;
    logic [9:0]         sync2_r;
    logic [CTRL_W-1:0]  ctrl_r;
    logic [NEV-1:0]     stat_r;
    logic [NEV-1:0]     mask_r;
    logic [1:0]         drv_en_r;
    logic [1:0]         rxd_r;
    logic [3:0]         irqs_r;
    logic               irq_r;
    logic               aw_full_r;
    logic               w_full_r;
    logic [ADDR_W-1:0]  waddr_r;
    logic [31:0]        wdata_r;
    logic               wstrb0_r;
    logic               awready_r;
    logic               wready_r;
    logic               bvalid_r;
    logic [1:0]         bresp_r;
    logic               arready_r;
    logic               rvalid_r;
    logic [1:0]         rresp_r;
    logic [31:0]        rdata_r;

    // pin inputs pass two flops; only sync2_r is read
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end
        else
        begin
            sync1_r <= {uart_irq_in, line_rxd, uart_txd, uart_rts_n};
            sync2_r <= sync1_r;
        end
    end

    wire logic [1:0] rts_s  = sync2_r[1:0];
    wire logic [1:0] txd_s  = sync2_r[3:2];
    wire logic [1:0] lrx_s  = sync2_r[5:4];
    wire logic [3:0] uirq_s = sync2_r[9:6];

    wire qlm_mode_t  mode3  = ch3_mode(ctrl_r[B_232], ctrl_r[B_422]);
    wire logic       is485_4 = ctrl_r[B_485];
    wire logic [1:0] is485  = {is485_4, mode3 == QLM_M485};
    wire logic [1:0] diff   = {1'b1, mode3 != QLM_M232};

    // driver follows rts_n only in RS485 mode
    wire logic [1:0] drv_nxt = diff & (~is485 | ~rts_s);
    // echo own transmit data while driving in RS485 mode
    wire logic [1:0] rxd_nxt = (is485 & ~rts_s & txd_s)
                             | (~(is485 & ~rts_s) & lrx_s);
    wire logic [3:0] ev = {drv_en_r[1] & ~drv_nxt[1],
                           ~drv_en_r[1] & drv_nxt[1],
                           drv_en_r[0] & ~drv_nxt[0],
                           ~drv_en_r[0] & drv_nxt[0]};

    // bus handshakes
    wire logic aw_take = s_axi_awvalid & awready_r;
    wire logic w_take  = s_axi_wvalid & wready_r;
    wire logic ar_take = s_axi_arvalid & arready_r;
    wire logic wr_do   = aw_full_r & w_full_r & ~bvalid_r;
    wire logic aw_full_nxt = (aw_full_r | aw_take) & ~wr_do;
    wire logic w_full_nxt  = (w_full_r | w_take) & ~wr_do;
    wire logic rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_rready);
    wire logic [3:0] wsel  = reg_sel(waddr_r);
    wire logic [3:0] rsel  = reg_sel(s_axi_araddr);
    wire logic       wr_b0 = wr_do & wstrb0_r;
    wire logic [NEV-1:0] w1c = (wr_b0 & wsel[2])
                             ? wdata_r[NEV-1:0] : EV_RST;
    // set wins over a same-cycle clear
    wire logic [NEV-1:0] stat_nxt = (stat_r & ~w1c) | ev;
    wire logic       irq_any = |(stat_r & mask_r);
    wire logic [31:0] stat_word =
        {20'h0_0000, uirq_s, rts_s, drv_en_r, is485_4, mode3};
    wire logic [31:0] rd_word =
        ({32{rsel[0]}} & {25'h000_0000, ctrl_r})
      | ({32{rsel[1]}} & stat_word)
      | ({32{rsel[2]}} & {28'h000_0000, stat_r})
      | ({32{rsel[3]}} & {28'h000_0000, mask_r});

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OK;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OK;
            rdata_r   <= ZERO32;
        end
        else
        begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            awready_r <= ~aw_full_nxt;
            wready_r  <= ~w_full_nxt;
            bvalid_r  <= wr_do | (bvalid_r & ~s_axi_bready);
            if (wr_do)
                bresp_r <= (|wsel) ? RESP_OK : RESP_ERR;
            arready_r <= ~rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_take)
            begin
                rdata_r <= rd_word;
                rresp_r <= (|rsel) ? RESP_OK : RESP_ERR;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            waddr_r  <= CTRL_OFF;
            wdata_r  <= ZERO32;
            wstrb0_r <= 1'b0;
        end
        else
        begin
            if (aw_take)
                waddr_r <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_r  <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
        end
    end

    // mode lines, terminations, slew and ch4 mode reset high
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r <= CTRL_RST;
            mask_r <= EV_RST;
            stat_r <= EV_RST;
        end
        else
        begin
            if (wr_b0 & wsel[0])
                ctrl_r <= wdata_r[CTRL_W-1:0];
            if (wr_b0 & wsel[3])
                mask_r <= wdata_r[NEV-1:0];
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            drv_en_r <= 2'h0;
            rxd_r    <= 2'h3;
            irqs_r   <= 4'h0;
            irq_r    <= 1'b0;
        end
        else
        begin
            drv_en_r <= drv_nxt;
            rxd_r    <= rxd_nxt;
            // each channel keeps its own interrupt line
            irqs_r   <= uirq_s;
            irq_r    <= irq_any;
        end
    end

    assign s_axi_awready     = awready_r;
    assign s_axi_wready      = wready_r;
    assign s_axi_bvalid      = bvalid_r;
    assign s_axi_bresp       = bresp_r;
    assign s_axi_arready     = arready_r;
    assign s_axi_rvalid      = rvalid_r;
    assign s_axi_rresp       = rresp_r;
    assign s_axi_rdata       = rdata_r;
    assign uart_rxd          = rxd_r;
    assign line_drv_en       = drv_en_r;
    assign uart_irq_out      = irqs_r;
    assign irq               = irq_r;
    assign ch3_rs232_enable  = ctrl_r[B_232];
    assign ch3_rs422_enable  = ctrl_r[B_422];
    assign ch3_termination_n = ctrl_r[B_T3];
    assign ch4_termination_n = ctrl_r[B_T4];
    // slew lines, low limits to about SLOW_KBPS
    assign ch3_slow_slew_n   = ctrl_r[B_S3];
    assign ch4_slow_slew_n   = ctrl_r[B_S4];
    assign ch4_rs485_enable  = ctrl_r[B_485];

    // checks
    logic seen_r;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            seen_r <= 1'b0;
        else
            seen_r <= 1'b1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_ctrl_wr;
        wr_b0 && wsel[0];
    endsequence
    sequence s_drive4;
        is485_4 && !rts_s[1];
    endsequence

    a_mode_232_wins: assert property (
        ctrl_r[B_232] |-> (mode3 == QLM_M232) ##1 (!line_drv_en[0]
        && uart_rxd[0] == $past(lrx_s[0])))
        else $error("ch3 rs232 mode drives the line");
    a_mode_485_fd: assert property (
        !ctrl_r[B_232] && !ctrl_r[B_422] |=> $past(mode3) == QLM_M485
        && drv_en_r[0] == !$past(rts_s[0]))
        else $error("ch3 rs485 decode wrong");
    a_reset_lines: assert property (
        !seen_r |-> ch3_rs232_enable && ch3_rs422_enable
        && ch4_rs485_enable)
        else $error("lines not high after reset");
    a_term_write: assert property (
        s_ctrl_wr |=> ch3_termination_n == $past(wdata_r[B_T3])
        && ch4_termination_n == $past(wdata_r[B_T4]))
        else $error("term lost");
    a_slew_write: assert property (
        s_ctrl_wr |=> ch3_slow_slew_n == $past(wdata_r[B_S3])
        && ch4_slow_slew_n == $past(wdata_r[B_S4]))
        else $error("slew lost");
    a_ch4_422_on: assert property (
        !is485_4 ##1 !is485_4 |-> drv_en_r[1])
        else $error("rs422 driver off");
    a_rts_drive: assert property (
        s_drive4 |=> line_drv_en[1])
        else $error("driver not on");
    a_rts_release: assert property (
        is485_4 && rts_s[1] |=> !drv_en_r[1])
        else $error("driver not off");
    a_echo_tx: assert property (
        s_drive4 |=> uart_rxd[1] == $past(txd_s[1]))
        else $error("no echo");
    a_irq_fwd: assert property (
        ##2 uart_irq_out == $past(uirq_s))
        else $error("uart irq not forwarded");
    a_set_wins: assert property (ev[0] && w1c[0] |=> stat_r[0])
        else $error("event lost on clear");
    a_irq_level: assert property (##1 irq == $past(irq_any))
        else $error("irq mismatch");
endmodule // qlm_line_ctrl

/* pkg/qlm_pkg.sv */
/*
 * Constants for the line mode control around the quad UART channels.
 * Assumes a 32-bit AXI4-Lite master and UART pins from an external part.
 */
package qlm_pkg;
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  CTRL_OFF     = 8'h00;
    localparam logic [7:0]  STAT_OFF     = 8'h04;
    localparam logic [7:0]  IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0]  IRQ_MASK_OFF = 8'h0C;
    // control register fields
    localparam int          B_232        = 0;
    localparam int          B_422        = 1;
    localparam int          B_T3         = 2;
    localparam int          B_485        = 3;
    localparam int          B_T4         = 4;
    localparam int          B_S3         = 5;
    localparam int          B_S4         = 6;
    localparam int          CTRL_W       = 7;
    localparam logic [6:0]  CTRL_RST     = 7'h7F;
    // interrupt events: driver on / off, per differential channel
    localparam int          NEV          = 4;
    localparam logic [3:0]  EV_RST       = 4'h0;
    localparam int          SLOW_KBPS    = 250;
    localparam int          NUM_UART     = 4;
    // sync vector: irq[3:0], line rxd[1:0], txd[1:0], rts_n[1:0]
    localparam logic [9:0]  SYNC_RST     = 10'h03F;
    localparam logic [1:0]  RESP_OK      = 2'h0;
    localparam logic [1:0]  RESP_ERR     = 2'h2;
    localparam logic [31:0] ZERO32       = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        QLM_M232 = 3'b001,
        QLM_M485 = 3'b010,
        QLM_M422 = 3'b100
    } qlm_mode_t;
endpackage

/* test/qlm_remote_node.sv */
/* remote RS485/RS422 node on the line side of ch3 and ch4.
   assumes drv_en from the block; a driven pair reads idle 1, a released pair reads tx_bit. */
`timescale 1ns/100ps
module qlm_remote_node
(
    input  wire logic       sys_clk,
    input  wire logic [1:0] drv_en,
    input  wire logic [1:0] tx_bit,
    output logic      [1:0] rxd
);
    // one talker per pair
    // remote stays silent while our driver owns the pair
    always_ff @(posedge sys_clk)
        rxd <= (~drv_en & tx_bit) | drv_en;
endmodule // qlm_remote_node

/* test/quad_uart_line_mode_control_test.sv */
/* self-checking bench for the line mode control block.
   assumes a 100 MHz clock and an AXI4-Lite master in this bench. */
`timescale 1ns/100ps
module quad_uart_line_mode_control_test import qlm_pkg::*;;
    logic        sys_clk, nrst, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, uart_irq_in, uart_irq_out;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, uart_rts_n, uart_txd, line_rxd;
    logic [1:0]  uart_rxd, line_drv_en, rmt_tx;
    logic        ch3_rs232_enable, ch3_rs422_enable, ch3_termination_n;
    logic        ch4_termination_n, ch3_slow_slew_n, ch4_slow_slew_n;
    logic        ch4_rs485_enable;
    wire  [6:0]  ctl = {ch4_slow_slew_n, ch3_slow_slew_n, ch4_termination_n,
        ch4_rs485_enable, ch3_termination_n, ch3_rs422_enable,
        ch3_rs232_enable};
    int          num_errors;
    int          total_checks;

    qlm_line_ctrl dut (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uart_rts_n, .uart_txd,
        .line_rxd, .uart_irq_in, .uart_rxd, .line_drv_en, .uart_irq_out,
        .ch3_rs232_enable, .ch3_rs422_enable, .ch3_termination_n,
        .ch4_termination_n, .ch3_slow_slew_n, .ch4_slow_slew_n,
        .ch4_rs485_enable, .irq);
    qlm_remote_node rmt (.sys_clk, .drv_en(line_drv_en), .tx_bit(rmt_tx),
        .rxd(line_rxd));

    always #5 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_t)
        begin
            @(negedge sys_clk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t  = s_axi_wvalid && s_axi_wready;
            b_t  = s_axi_bvalid;
            r    = s_axi_bresp;
            @(posedge sys_clk);
            if (aw_t)
                s_axi_awvalid <= 1'b0;
            if (w_t)
                s_axi_wvalid <= 1'b0;
            if (b_t)
                s_axi_bready <= 1'b0;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic ar_t, r_t;
        r_t = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!r_t)
        begin
            @(negedge sys_clk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t  = s_axi_rvalid;
            d    = s_axi_rdata;
            r    = s_axi_rresp;
            @(posedge sys_clk);
            if (ar_t)
                s_axi_arvalid <= 1'b0;
            if (r_t)
                s_axi_rready <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk(32'(r), 32'(RESP_OK));
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(d, e);
    endtask

    task automatic pins(input logic [1:0] rts, input logic [1:0] txd);
        @(posedge sys_clk);
        uart_rts_n <= rts;
        uart_txd   <= txd;
        repeat (5) @(negedge sys_clk);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        sys_clk = 1'b0;
        nrst = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        uart_irq_in = 4'h0;
        uart_rts_n = 2'h3;
        uart_txd = 2'h3;
        rmt_tx = 2'h0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (5) @(negedge sys_clk);
        chk(32'(ctl), 32'h7F);
        rchk(CTRL_OFF, 32'h7F);
        chk(32'(line_drv_en), 32'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            wr(CTRL_OFF, 32'h7C | 32'(i));
            repeat (5) @(negedge sys_clk);
            chk(32'(ctl), 32'h7C | 32'(i));
            rchk(STAT_OFF, 32'hC8 | (i[0] ? 32'h1
                : i[1] ? 32'h14 : 32'h2));
        end
        $display("ch3 mode test done");
        wr(CTRL_OFF, 32'h0);
        repeat (5) @(negedge sys_clk);
        chk(32'(ctl), 32'h0);
        chk(32'(line_drv_en), 32'h2);
        wr(CTRL_OFF, 32'h8);
        pins(2'h3, 2'h3);
        chk(32'(line_drv_en), 32'h0);
        chk(32'(uart_rxd), 32'h0);
        // remote node talks while both drivers are released
        @(posedge sys_clk);
        rmt_tx <= 2'h3;
        repeat (5) @(negedge sys_clk);
        chk(32'(uart_rxd), 32'h3);
        pins(2'h0, 2'h1);
        chk(32'(line_drv_en), 32'h3);
        chk(32'(uart_rxd), 32'h1);
        pins(2'h0, 2'h2);
        chk(32'(uart_rxd), 32'h2);
        wr(CTRL_OFF, 32'h0);
        pins(2'h0, 2'h0);
        chk(32'(uart_rxd), 32'h2);
        $display("direction test done");
        pins(2'h3, 2'h0);
        wr(IRQ_STAT_OFF, 32'hF);
        rchk(IRQ_STAT_OFF, 32'h0);
        wr(IRQ_MASK_OFF, 32'h1);
        pins(2'h2, 2'h0);
        chk(32'(irq), 32'h1);
        rchk(IRQ_STAT_OFF, 32'h1);
        wr(IRQ_STAT_OFF, 32'h1);
        repeat (2) @(negedge sys_clk);
        chk(32'(irq), 32'h0);
        pins(2'h3, 2'h0);
        chk(32'(irq), 32'h0);
        rchk(IRQ_STAT_OFF, 32'h2);
        // clear lands in the same cycle as the ch3 driver-on event
        @(posedge sys_clk);
        uart_rts_n <= 2'h2;
        wr(IRQ_STAT_OFF, 32'h3);
        rchk(IRQ_STAT_OFF, 32'h1);
        chk(32'(irq), 32'h1);
        $display("interrupt test done");
        @(posedge sys_clk);
        uart_irq_in <= 4'hA;
        repeat (5) @(negedge sys_clk);
        chk(32'(uart_irq_out), 32'hA);
        axi_wr(8'h10, 32'h0, r);
        chk(32'(r), 32'(RESP_ERR));
        axi_rd(8'h10, d, r);
        chk(32'(r), 32'(RESP_ERR));
        chk(d, 32'h0);
        // write with byte lane 0 off must leave the control lines alone
        @(posedge sys_clk);
        s_axi_wstrb <= 4'hE;
        wr(CTRL_OFF, 32'h7F);
        rchk(CTRL_OFF, 32'h0);
        $display("forward and map test done");
        give_verdict();
    end
endmodule // quad_uart_line_mode_control_test
